// >>> rtl/bzl_pkg.sv
// Constants and types shared by the border zone layout generator
package bzl_pkg;

    // Sector address space and block geometry
    localparam int               BZL_PSN_W        = 24;
    localparam int               BZL_POS_W        = 12;
    localparam int               BZL_BP_W         = 11;
    localparam int               BZL_ECC_SECT_LOG = 4;
    localparam logic [23:0]      BZL_MIN_BO_PSN   = 24'h03FEFF;
    localparam logic [23:0]      BZL_SIZE2_PSN    = 24'h0B2600;
    localparam logic [23:0]      BZL_SIZE3_PSN    = 24'h165700;
    localparam logic [23:0]      BZL_DZ_START_PSN = 24'h030000;

    // Zone sizes in ECC blocks for the three Layer 0 bands
    localparam logic [11:0]      BZL_SIZE1_BLK    = 12'h734;
    localparam logic [11:0]      BZL_SIZE2_BLK    = 12'h98A;
    localparam logic [11:0]      BZL_SIZE3_BLK    = 12'hB9C;

    // Unit positions counted from the start of the zone, and unit offsets from M or N
    localparam logic [11:0]      BZL_UP_RMD_LAST  = 12'h004;
    localparam logic [11:0]      BZL_UP_STOP_A    = 12'h025;
    localparam logic [11:0]      BZL_UP_STOP_B    = 12'h026;
    localparam logic [11:0]      BZL_UP_M_MIN     = 12'h027;
    localparam logic [11:0]      BZL_MK1_OFS      = 12'h000;
    localparam logic [11:0]      BZL_MK2_OFS      = 12'h00A;
    localparam logic [11:0]      BZL_MK3_OFS      = 12'h014;
    localparam logic [11:0]      BZL_GUARD_OFS    = 12'h002;
    localparam logic [11:0]      BZL_M_SPAN       = 12'h017;
    localparam logic [11:0]      BZL_FMT_FIRST    = 12'h001;
    localparam logic [11:0]      BZL_FMT_LAST     = 12'h005;
    localparam logic [11:0]      BZL_N_LAST       = 12'h006;

    // Byte positions inside the updated format block
    localparam logic [10:0]      BZL_BP_CATEGORY  = 11'h000;
    localparam logic [10:0]      BZL_BP_RATE      = 11'h001;
    localparam logic [10:0]      BZL_BP_ALLOC_LO  = 11'h004;
    localparam logic [10:0]      BZL_BP_ALLOC_HI  = 11'h00F;
    localparam logic [10:0]      BZL_BP_RSV_LO    = 11'h01C;
    localparam logic [10:0]      BZL_BP_SECT_LO   = 11'h020;
    localparam logic [10:0]      BZL_BP_SECT_HI   = 11'h027;
    localparam logic [10:0]      BZL_BP_REMAP_BLOCK_VALID_FLAGS      = 11'h02A;
    localparam logic [10:0]      BZL_BP_RSV2_LO   = 11'h02B;
    localparam logic [10:0]      BZL_BP_RSV2_HI   = 11'h1FF;

    // What a unit carries
    typedef enum logic [3:0] {
        BZL_K_RMD,
        BZL_K_ZERO,
        BZL_K_STOP,
        BZL_K_MARK_ZERO,
        BZL_K_MARK_FMT,
        BZL_K_SKIP,
        BZL_K_GUARD,
        BZL_K_LINK_LOSS,
        BZL_K_FMT
    } bzl_kind_e;

    // Area type attribute of a unit
    typedef enum logic [1:0] {
        BZL_A_DATA,
        BZL_A_LEAD_OUT,
        BZL_A_MIDDLE
    } bzl_attr_e;

endpackage

// >>> rtl/bzl_zone_size.sv
// Start sector check and zone size lookup for a Layer 0 Border-out
`timescale 1ns/1ns
module bzl_zone_size
    import bzl_pkg::*;
(
    input  wire logic [23:0] bo_psn_in,
    input  wire logic [23:0] l0_end_in,
    output logic      [11:0] size_out,
    output logic             psn_ok_out
);

    // Band lookup; above the Layer 0 end the start is refused
    always_comb begin
        if (bo_psn_in >= BZL_SIZE3_PSN) begin
            size_out = BZL_SIZE3_BLK;
        end else if (bo_psn_in >= BZL_SIZE2_PSN) begin
            size_out = BZL_SIZE2_BLK;
        end else begin
            size_out = BZL_SIZE1_BLK;
        end
    end

    // Must lie past the floor and on a block boundary
    assign psn_ok_out = (bo_psn_in > BZL_MIN_BO_PSN)
                      && (bo_psn_in[BZL_ECC_SECT_LOG-1:0] == '0)
                      && (bo_psn_in <= l0_end_in);

endmodule

// >>> rtl/bzl_fmt_byte.sv
// Byte selector for the updated physical format block
`timescale 1ns/1ns
module bzl_fmt_byte
    import bzl_pkg::*;
(
    input  wire logic [10:0] bp_in,
    input  wire logic [7:0]  prerec_byte_in,
    input  wire logic [7:0]  category_byte_in,
    input  wire logic [7:0]  rate_byte_in,
    input  wire logic [7:0]  remap_flags_in,
    input  wire logic [23:0] max_rec_psn_in,
    input  wire logic [23:0] l0_end_in,
    input  wire logic [23:0] bo_psn_in,
    input  wire logic [23:0] bi_psn_in,
    output logic      [7:0]  byte_out
);

    logic [95:0] alloc_v;
    logic [63:0] sect_v;
    logic [3:0]  alloc_idx;
    logic [2:0]  sect_idx;

    // Updated fields, most significant byte first
    assign alloc_v = {8'h00, BZL_DZ_START_PSN, 8'h00, max_rec_psn_in,
                      8'h00, l0_end_in};
    assign sect_v  = {8'h00, bo_psn_in, 8'h00, bi_psn_in};
    assign alloc_idx = 4'(bp_in - BZL_BP_ALLOC_LO);
    assign sect_idx  = 3'(bp_in - BZL_BP_SECT_LO);

    // Copy the pre-recorded byte unless an updated field covers it
    always_comb begin
        byte_out = prerec_byte_in;
        if (bp_in == BZL_BP_CATEGORY) begin
            byte_out = category_byte_in;
        end else if (bp_in == BZL_BP_RATE) begin
            byte_out = rate_byte_in;
        end else if (bp_in >= BZL_BP_ALLOC_LO && bp_in <= BZL_BP_ALLOC_HI) begin
            byte_out = alloc_v[8*(4'hB - alloc_idx) +: 8];
        end else if (bp_in >= BZL_BP_RSV_LO && bp_in < BZL_BP_SECT_LO) begin
            byte_out = 8'h00;
        end else if (bp_in >= BZL_BP_SECT_LO && bp_in <= BZL_BP_SECT_HI) begin
            byte_out = sect_v[8*(3'h7 - sect_idx) +: 8];
        end else if (bp_in == BZL_BP_REMAP_BLOCK_VALID_FLAGS) begin
            byte_out = remap_flags_in;
        end else if (bp_in >= BZL_BP_RSV2_LO && bp_in <= BZL_BP_RSV2_HI) begin
            byte_out = 8'h00;
        end
    end

endmodule

// >>> rtl/bzl_layout_gen.sv
// Border zone layout generator: start checks, unit sequencing, contents
`timescale 1ns/1ns

// Summary of operation
// - Refuse a Border-out start sector not above 03FEFF.
// - Refuse a Border-out start not on an ECC block boundary.
// - Zone size is 1844, 2442 or 2972 blocks by start band.
// - Each unit position stands for exactly one ECC block.
// - First marker address is half the sum of both start sectors.
// - Units 0 to 4 carry five copies of current management data.
// - Those five copies carry a zero data type bit.
// - Filler units between the named areas are all-zero blocks.
// - Units 37 and 38 are a zero stop block with lead-out attribute.
// - Three two-unit markers at M, M+10, M+20, each with a guard.
// - With no following bordered area, no marker is recorded.
// - With a following area, markers are zeros or the format block.
// - A format-block marker holds it twice by lossless linking.
// - On finalization with a following area, all markers become zeros with middle attribute.
// - A guard unit becomes linking loss once its marker is recorded.
// - Unit N links, N+1..N+5 repeat the format block, N+6 guards.
// - Format block copies pre-recorded bytes except bytes 0,1,4-15,28-39,42-511.
// - Bytes 4-15 hold allocation, 32-39 hold both start sectors.
// - Both start sectors are offered for recording in lead-in or Border-in.
// - A zone is the current Border-out then the next Border-in.
// - Under the fourth management format a Layer 1 mirror zone is flagged.
// - A zero next Border-in start means no following bordered area.
module bzl_layout_gen
    import bzl_pkg::*;
(
    input  wire logic                clk_in,
    input  wire logic                rst_n_in,
    input  wire logic                start_in,
    input  wire logic [23:0]         bo_psn_in,
    input  wire logic [23:0]         bi_psn_in,
    input  wire logic [23:0]         l0_end_in,
    input  wire logic [23:0]         max_rec_psn_in,
    input  wire logic [11:0]         m_ofs_in,
    input  wire logic [11:0]         n_ofs_in,
    input  wire logic                finalize_in,
    input  wire logic                marker_fmt_in,
    input  wire logic                format4_in,
    input  wire logic                unit_req_in,
    input  wire logic [10:0]         fmt_bp_in,
    input  wire logic [7:0]          prerec_byte_in,
    input  wire logic [7:0]          category_byte_in,
    input  wire logic [7:0]          rate_byte_in,
    input  wire logic [7:0]          remap_flags_in,
    output logic                     busy_out,
    output logic                     unit_ready_out,
    output logic                     unit_valid_out,
    output logic [11:0]              unit_pos_out,
    output logic [23:0]              unit_psn_out,
    output bzl_kind_e                unit_kind_out,
    output bzl_attr_e                unit_attr_out,
    output logic                     unit_record_out,
    output logic                     data_type_zero_out,
    output logic                     lossless_twice_out,
    output logic                     reject_out,
    output logic                     done_out,
    output logic [11:0]              zone_blocks_out,
    output logic [23:0]              marker_psn_out,
    output logic [23:0]              rec_bo_psn_out,
    output logic [23:0]              rec_bi_psn_out,
    output logic                     superficial_out,
    output logic [7:0]               fmt_byte_out
);

    typedef enum logic [1:0] {BZL_S_IDLE, BZL_S_RUN, BZL_S_DONE} bzl_state_e;

    bzl_state_e  state_q;
    logic [23:0] bo_q;
    logic [23:0] bi_q;
    logic [11:0] m_q;
    logic [11:0] n_q;
    logic [11:0] pos_q;
    logic        final_q;
    logic        mfmt_q;
    logic [11:0] size_w;
    logic        psn_ok_w;
    logic        layout_ok_w;
    logic        accept_w;
    logic        take_w;
    logic        last_w;
    logic        next_area_w;
    logic [12:0] n_end_w;
    logic [12:0] m_end_w;
    logic [24:0] mk_sum_w;
    logic [7:0]  fmt_byte_w;
    bzl_kind_e   kind_w;
    bzl_attr_e   attr_w;

    bzl_zone_size u_size (
        .bo_psn_in  (bo_psn_in),
        .l0_end_in  (l0_end_in),
        .size_out   (size_w),
        .psn_ok_out (psn_ok_w)
    );

    bzl_fmt_byte u_fmt (
        .bp_in            (fmt_bp_in),
        .prerec_byte_in   (prerec_byte_in),
        .category_byte_in (category_byte_in),
        .rate_byte_in     (rate_byte_in),
        .remap_flags_in   (remap_flags_in),
        .max_rec_psn_in   (max_rec_psn_in),
        .l0_end_in        (l0_end_in),
        .bo_psn_in        (bo_q),
        .bi_psn_in        (bi_q),
        .byte_out         (fmt_byte_w)
    );

    // Layout must fit: markers after the stop block, N+6 inside the zone
    assign m_end_w  = {1'b0, m_ofs_in} + {1'b0, BZL_M_SPAN};
    assign n_end_w  = {1'b0, n_ofs_in} + {1'b0, BZL_N_LAST};
    assign layout_ok_w = (m_ofs_in >= BZL_UP_M_MIN)
                       && (m_end_w <= {1'b0, n_ofs_in})
                       && (n_end_w < {1'b0, size_w});
    assign accept_w = start_in && (state_q != BZL_S_RUN);
    assign take_w   = (state_q == BZL_S_RUN) && unit_req_in;
    assign last_w   = ({1'b0, pos_q} == {1'b0, n_q} + {1'b0, BZL_N_LAST});
    assign next_area_w = (bi_q != '0);
    assign mk_sum_w = {1'b0, bi_psn_in} + {1'b0, bo_psn_in};
    assign busy_out       = (state_q == BZL_S_RUN);
    assign unit_ready_out = (state_q == BZL_S_RUN);

    // Marker and guard position tests relative to M
    function automatic logic is_mark(input logic [11:0] p,
                                     input logic [11:0] m);
        logic [11:0] r;
        r = p - m;
        is_mark = (p >= m) && (r == BZL_MK1_OFS || r == BZL_MK1_OFS + 1
                || r == BZL_MK2_OFS || r == BZL_MK2_OFS + 1
                || r == BZL_MK3_OFS || r == BZL_MK3_OFS + 1);
    endfunction

    function automatic logic is_guard(input logic [11:0] p,
                                      input logic [11:0] m);
        logic [11:0] r;
        r = p - m;
        is_guard = (p >= m) && (r == BZL_MK1_OFS + BZL_GUARD_OFS
                 || r == BZL_MK2_OFS + BZL_GUARD_OFS
                 || r == BZL_MK3_OFS + BZL_GUARD_OFS);
    endfunction

    // Contents of the unit at pos_q; zero fill is the fallback
    always_comb begin
        kind_w = BZL_K_ZERO;
        attr_w = BZL_A_DATA;
        if (pos_q <= BZL_UP_RMD_LAST) begin
            kind_w = BZL_K_RMD;
        end else if (pos_q == BZL_UP_STOP_A || pos_q == BZL_UP_STOP_B) begin
            kind_w = BZL_K_STOP;
            attr_w = BZL_A_LEAD_OUT;
        end else if (is_mark(pos_q, m_q)) begin
            if (!next_area_w) begin
                kind_w = BZL_K_SKIP;
            end else if (final_q) begin
                kind_w = BZL_K_MARK_ZERO;
                attr_w = BZL_A_MIDDLE;
            end else if (mfmt_q) begin
                kind_w = BZL_K_MARK_FMT;
            end else begin
                kind_w = BZL_K_MARK_ZERO;
            end
        end else if (is_guard(pos_q, m_q)) begin
            // Recorded marker turns its guard into a link point
            kind_w = next_area_w ? BZL_K_LINK_LOSS : BZL_K_GUARD;
        end else if (pos_q == n_q) begin
            kind_w = BZL_K_LINK_LOSS;
        end else if (pos_q >= n_q + BZL_FMT_FIRST
                     && pos_q <= n_q + BZL_FMT_LAST) begin
            kind_w = BZL_K_FMT;
        end else if (last_w) begin
            kind_w = BZL_K_GUARD;
        end
    end

    // Sequencer: one zone walk per accepted start
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_q <= BZL_S_IDLE;
        end else if (accept_w) begin
            state_q <= (psn_ok_w && layout_ok_w) ? BZL_S_RUN : BZL_S_IDLE;
        end else if (take_w && last_w) begin
            state_q <= BZL_S_DONE;
        end
    end

    // Zone parameters captured at start
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            bo_q    <= '0;
            bi_q    <= '0;
            m_q     <= '0;
            n_q     <= '0;
            final_q <= 1'b0;
            mfmt_q  <= 1'b0;
            zone_blocks_out <= '0;
            marker_psn_out  <= '0;
            superficial_out <= 1'b0;
        end else if (accept_w && psn_ok_w && layout_ok_w) begin
            bo_q    <= bo_psn_in;
            bi_q    <= bi_psn_in;
            m_q     <= m_ofs_in;
            n_q     <= n_ofs_in;
            final_q <= finalize_in;
            mfmt_q  <= marker_fmt_in;
            zone_blocks_out <= size_w;
            marker_psn_out  <= mk_sum_w[24:1];
            superficial_out <= format4_in;
        end
    end

    // Start sectors handed on for lead-in or Border-in recording
    assign rec_bo_psn_out = bo_q;
    assign rec_bi_psn_out = bi_q;

    // Unit position counter, one block per request
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pos_q <= '0;
        end else if (accept_w) begin
            pos_q <= '0;
        end else if (take_w && !last_w) begin
            pos_q <= pos_q + 12'h001;
        end
    end

    // Registered unit descriptor
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            unit_valid_out     <= 1'b0;
            unit_pos_out       <= '0;
            unit_psn_out       <= '0;
            unit_kind_out      <= BZL_K_ZERO;
            unit_attr_out      <= BZL_A_DATA;
            unit_record_out    <= 1'b0;
            data_type_zero_out <= 1'b0;
            lossless_twice_out <= 1'b0;
        end else begin
            unit_valid_out <= take_w;
            if (take_w) begin
                unit_pos_out  <= pos_q;
                // One ECC block of sixteen sectors per unit
                unit_psn_out  <= bo_q + {pos_q, {BZL_ECC_SECT_LOG{1'b0}}};
                unit_kind_out <= kind_w;
                unit_attr_out <= attr_w;
                unit_record_out    <= (kind_w != BZL_K_SKIP);
                data_type_zero_out <= (kind_w == BZL_K_RMD);
                lossless_twice_out <= (kind_w == BZL_K_MARK_FMT);
            end
        end
    end

    // Status pulses and levels
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            reject_out <= 1'b0;
            done_out   <= 1'b0;
        end else begin
            reject_out <= accept_w && !(psn_ok_w && layout_ok_w);
            if (accept_w) begin
                done_out <= 1'b0;
            end else if (take_w && last_w) begin
                done_out <= 1'b1;
            end
        end
    end

    // Format byte is registered; the read costs one cycle of latency
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            fmt_byte_out <= 8'h00;
        end else begin
            fmt_byte_out <= fmt_byte_w;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_take;
        (state_q == BZL_S_RUN) && unit_req_in;
    endsequence

    sequence s_start_low;
        accept_w && (bo_psn_in <= BZL_MIN_BO_PSN);
    endsequence

    a_reject_low_psn: assert property (s_start_low |=> reject_out && !busy_out)
        else $error("low Border-out start not refused");

    a_reject_misalign: assert property (accept_w && bo_psn_in[3:0] != 4'h0
        |=> reject_out ##1 !reject_out)
        else $error("misaligned Border-out start not refused");

    a_zone_band: assert property (busy_out && bo_q < BZL_SIZE2_PSN
        |-> zone_blocks_out == BZL_SIZE1_BLK)
        else $error("zone size wrong for low band");

    a_unit_order: assert property (s_take |=> unit_valid_out
        && unit_pos_out == $past(pos_q)
        && unit_psn_out == bo_q + {$past(pos_q), 4'h0})
        else $error("unit emitted out of order");

    a_marker_addr: assert property (accept_w && psn_ok_w && layout_ok_w
        |=> marker_psn_out == ($past(bo_psn_in) + $past(bi_psn_in)) >> 1)
        else $error("marker address wrong");

    a_rmd_dtype: assert property (unit_valid_out && unit_pos_out <= 12'h004
        |-> unit_kind_out == BZL_K_RMD && data_type_zero_out)
        else $error("management copy wrong");

    a_stop_attr: assert property (unit_valid_out
        && (unit_pos_out == BZL_UP_STOP_A || unit_pos_out == BZL_UP_STOP_B)
        |-> unit_kind_out == BZL_K_STOP && unit_attr_out == BZL_A_LEAD_OUT)
        else $error("stop block wrong");

    a_no_marker: assert property (unit_valid_out && bi_q == '0
        |-> unit_kind_out != BZL_K_MARK_ZERO
            && unit_kind_out != BZL_K_MARK_FMT)
        else $error("marker recorded with no next area");

    a_done_last: assert property (s_take ##0 last_w
        |=> done_out && unit_kind_out == BZL_K_GUARD ##1 !busy_out)
        else $error("done not raised after last unit");

    a_fmt_remap_block_valid_flags: assert property (fmt_bp_in == BZL_BP_REMAP_BLOCK_VALID_FLAGS
        |=> fmt_byte_out == $past(remap_flags_in))
        else $error("byte 42 not updated");

endmodule

// >>> bench/bzl_chan_model.sv
// Recording channel model that pulls units from the generator
`timescale 1ns/1ns
module bzl_chan_model (
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    input  wire logic go_in,
    input  wire logic slow_in,
    input  wire logic ready_in,
    output logic      unit_req_out
);
    // Ask only while ready; slow mode leaves gaps between requests
    always_ff @(negedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            unit_req_out <= 1'b0;
        end else begin
            unit_req_out <= go_in && ready_in
                            && !(slow_in && unit_req_out);
        end
    end
endmodule

// >>> bench/bzl_layout_gen_tb_top.sv
// Self-checking bench for the border zone layout generator
`timescale 1ns/1ns
module bzl_layout_gen_tb_top;
    import bzl_pkg::*;
    localparam int M = 39;
    localparam int N = 62;
    logic             clk_in, rst_n_in, start_in, unit_req_in, go, slow;
    logic             finalize_in, marker_fmt_in, format4_in;
    logic [23:0]      bo_psn_in, bi_psn_in, l0_end_in, max_rec_psn_in;
    logic [23:0]      cur_bo, cur_bi, unit_psn_out, marker_psn_out;
    logic [23:0]      rec_bo_psn_out, rec_bi_psn_out;
    logic             cur_fin, cur_mf;
    logic [11:0]      m_ofs_in, n_ofs_in, unit_pos_out, zone_blocks_out;
    logic [10:0]      fmt_bp_in;
    logic [7:0]       prerec_byte_in, category_byte_in, rate_byte_in;
    logic [7:0]       remap_flags_in, fmt_byte_out;
    logic             busy_out, unit_ready_out, unit_valid_out, reject_out;
    logic             unit_record_out, data_type_zero_out, lossless_twice_out;
    logic             done_out, superficial_out;
    bzl_kind_e        unit_kind_out;
    bzl_attr_e        unit_attr_out;
    logic [44:0]      unit_seen;
    int               num_errors, n_compared, exp_pos;

    bzl_layout_gen uut (.*);
    bzl_chan_model chan (.clk_in(clk_in), .rst_n_in(rst_n_in), .go_in(go),
        .slow_in(slow), .ready_in(unit_ready_out), .unit_req_out(unit_req_in));

    // Free-running 100 MHz clock
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp,
                         input string what);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: %s got %h want %h", $time, what,
                     seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("counts: %0d compared, %0d wrong", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Expected descriptor of unit p, built from the zone layout
    function automatic logic [63:0] exp_unit(input int p);
        bzl_kind_e k;
        bzl_attr_e a;
        int        d;
        d = p - M;
        k = BZL_K_ZERO;
        a = BZL_A_DATA;
        if (p <= 4) begin
            k = BZL_K_RMD;
        end else if (p inside {37, 38}) begin
            k = BZL_K_STOP;
            a = BZL_A_LEAD_OUT;
        end else if (d inside {0, 1, 10, 11, 20, 21}) begin
            k = (cur_bi == 0) ? BZL_K_SKIP :
                (cur_fin || !cur_mf) ? BZL_K_MARK_ZERO : BZL_K_MARK_FMT;
            a = (cur_bi != 0 && cur_fin) ? BZL_A_MIDDLE : BZL_A_DATA;
        end else if (d inside {2, 12, 22}) begin
            k = (cur_bi != 0) ? BZL_K_LINK_LOSS : BZL_K_GUARD;
        end else if (p == N) begin
            k = BZL_K_LINK_LOSS;
        end else if (p > N && p <= N + 5) begin
            k = BZL_K_FMT;
        end else if (p == N + 6) begin
            k = BZL_K_GUARD;
        end
        return {12'(p), k, a, k != BZL_K_SKIP, k == BZL_K_RMD,
                k == BZL_K_MARK_FMT, cur_bo + 24'(p * 16)};
    endfunction

    // Every delivered unit is compared in the cycle it stands
    assign unit_seen = {unit_pos_out, unit_kind_out, unit_attr_out,
        unit_record_out, data_type_zero_out, lossless_twice_out, unit_psn_out};
    always @(negedge clk_in) begin
        if (unit_valid_out === 1'b1) begin
            check(unit_seen, exp_unit(exp_pos), "unit");
            exp_pos++;
        end
    end

    task automatic refuse(input logic [23:0] bo);
        bo_psn_in = bo;
        start_in = 1'b1;
        @(negedge clk_in);
        start_in = 1'b0;
        check({reject_out, busy_out}, 2'b10, "refuse");
        @(negedge clk_in);
        check(reject_out, 1'b0, "pulse");
    endtask

    // One full zone walk with the channel pulling every unit
    task automatic walk(input logic [23:0] bo, input logic [23:0] bi,
                        input logic fin, input logic mf, input int zone);
        logic [24:0] s;
        int          t;
        cur_bo = bo;
        cur_bi = bi;
        cur_fin = fin;
        cur_mf = mf;
        exp_pos = 0;
        bo_psn_in = bo;
        bi_psn_in = bi;
        finalize_in = fin;
        marker_fmt_in = mf;
        format4_in = mf;
        start_in = 1'b1;
        @(negedge clk_in);
        start_in = 1'b0;
        s = {1'b0, bo} + {1'b0, bi};
        check({busy_out, done_out, zone_blocks_out}, {2'b10, 12'(zone)}, "size");
        check(superficial_out, mf, "layer1");
        check({marker_psn_out, rec_bo_psn_out, rec_bi_psn_out}, {s[24:1], bo, bi}, "addr");
        go = 1'b1;
        for (t = 0; t < 400 && done_out !== 1'b1; t++) begin
            @(negedge clk_in);
        end
        go = 1'b0;
        // A used-up bound counts once; the end check below fails as well
        if (t == 400) begin
            num_errors++;
        end
        // Let the monitor count the last unit before looking at the tally
        @(negedge clk_in);
        check({done_out, busy_out, 32'(exp_pos)}, {2'b10, 32'(N + 7)}, "end");
        $display("walk at %h done", bo);
    endtask

    task automatic fb(input logic [10:0] bp, input logic [7:0] exp);
        fmt_bp_in = bp;
        prerec_byte_in = bp[7:0] ^ 8'hA5;
        @(negedge clk_in);
        check(fmt_byte_out, exp, "fmt");
    endtask

    initial begin
        {rst_n_in, start_in, go, slow, finalize_in, marker_fmt_in} = 6'h00;
        {format4_in, bo_psn_in, bi_psn_in, fmt_bp_in} = 60'h0;
        {m_ofs_in, n_ofs_in} = {12'(M), 12'(N)};
        {l0_end_in, max_rec_psn_in} = {24'h1FFFF0, 24'h1A2B3C};
        {category_byte_in, rate_byte_in, remap_flags_in} = 24'h3C5E96;
        prerec_byte_in = 8'h00;
        repeat (10) @(negedge clk_in);
        rst_n_in = 1'b1;
        check({busy_out, done_out, reject_out, unit_valid_out}, 4'h0, "reset");
        refuse(24'h03FEFF);
        refuse(24'h03FF08);
        refuse(24'h200000);
        $display("refusals done");
        walk(24'h03FF00, 24'h000000, 1'b0, 1'b0, 1844);
        slow = 1'b1;
        walk(24'h0B2600, 24'h0C0000, 1'b1, 1'b1, 2442);
        slow = 1'b0;
        walk(24'h165700, 24'h170000, 1'b0, 1'b1, 2972);
        walk(24'h0B25F0, 24'h0C1230, 1'b0, 1'b0, 1844);
        fb(11'h000, 8'h3C);
        fb(11'h001, 8'h5E);
        fb(11'h02A, 8'h96);
        fb(11'h002, 8'hA7);
        fb(11'h7FF, 8'h5A);
        fb(11'h004, 8'h00);
        fb(11'h005, 8'h03);
        fb(11'h00A, 8'h2B);
        fb(11'h00F, 8'hF0);
        fb(11'h01C, 8'h00);
        fb(11'h021, 8'h0B);
        fb(11'h023, 8'hF0);
        fb(11'h024, 8'h00);
        fb(11'h026, 8'h12);
        fb(11'h1FF, 8'h00);
        $display("format bytes done");
        print_verdict();
    end
endmodule
